/* gpcs_pkg.sv */
package gpcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_REM_TIME_ALARM = 9'h002;
  localparam logic [8:0] IDX_DESIGN_VOLTAGE = 9'h004;
  localparam logic [8:0] IDX_CYCLE_SEED     = 9'h00C;
  localparam logic [8:0] IDX_PACK_OPTION    = 9'h028;
  localparam logic [8:0] IDX_FILTER_THRESH  = 9'h02C;
  localparam logic [8:0] IDX_DESIGN_CAP     = 9'h032;
  localparam logic [8:0] IDX_FULL_CAP       = 9'h036;
  localparam logic [8:0] IDX_CHARGE_EFF     = 9'h054;
  localparam logic [8:0] IDX_SENSE_GAIN     = 9'h0CB;
  localparam logic [8:0] IDX_COUNTER_GAIN   = 9'h0CD;
  localparam logic [8:0] IDX_COUNTER_OFFSET = 9'h0D2;
  localparam logic [8:0] IDX_GROUND_OFFSET  = 9'h0D4;
  localparam logic [8:0] IDX_CONV_OFFSET    = 9'h0D5;
  localparam logic [8:0] IDX_FAULT_CLEAR    = 9'h130;
  localparam logic [8:0] IDX_END_DSG_ZERO   = 9'h137;
  localparam logic [8:0] IDX_EXTRA_OPTION   = 9'h139;
  localparam logic [8:0] IDX_BATT_MODE      = 9'h170;
  localparam logic [8:0] IDX_REM_CAP_ALARM  = 9'h171;
  localparam logic [8:0] IDX_CYCLE_THRESH   = 9'h172;
  localparam logic [8:0] IDX_CYCLE_NOW      = 9'h173;
  localparam logic [8:0] IDX_DESIGN_CAP_RPT = 9'h174;
  localparam logic [8:0] IDX_INT_STATUS     = 9'h175;
  localparam logic [8:0] IDX_INT_MASK       = 9'h176;

  // Pack option byte fields
  localparam int POS_LED_SOURCE = 7;
  localparam int POS_LED_HIGH   = 6;
  localparam int POS_LED_LOW    = 5;
  localparam int POS_HOST_PEC   = 4;
  localparam int POS_CHG_PEC    = 3;
  localparam int POS_BCAST_DIS  = 2;
  localparam int POS_CELL_HIGH  = 1;
  localparam int POS_CELL_LOW   = 0;

  // Battery mode fields
  localparam int POS_MODE_MWH   = 0;
  localparam int POS_MODE_BCAST = 1;

  // Interrupt status bits
  localparam int INT_W        = 3;
  localparam int INT_SLEEP    = 0;
  localparam int INT_LEARN    = 1;
  localparam int INT_CYCLE    = 2;

  // Reset values
  localparam logic [15:0] RST_REM_TIME    = 16'h000A;
  localparam logic [15:0] RST_VOLTAGE     = 16'h3A98;
  localparam logic [15:0] RST_CYCLE_SEED  = 16'h0000;
  localparam logic [7:0]  RST_PACK_OPTION = 8'h03;
  localparam logic [7:0]  RST_FILTER      = 8'h64;
  localparam logic [15:0] RST_DESIGN_CAP  = 16'h1000;
  localparam logic [15:0] RST_FULL_CAP    = 16'h1000;
  localparam logic [7:0]  RST_CHARGE_EFF  = 8'hFF;
  localparam logic [15:0] RST_SENSE_GAIN  = 16'h3BD0;
  localparam logic [31:0] RST_COUNTER_GN  = 32'h0001_0000;
  localparam logic [15:0] RST_CNT_OFFSET  = 16'h0000;
  localparam logic [7:0]  RST_GND_OFFSET  = 8'h00;
  localparam logic [7:0]  RST_CONV_OFFSET = 8'h00;
  localparam logic [7:0]  RST_FAULT_CLEAR = 8'h1E;
  localparam logic [15:0] RST_END_DSG     = 16'h0BB8;
  localparam logic [7:0]  RST_EXTRA_OPT   = 8'h00;
  localparam logic [1:0]  RST_BATT_MODE   = 2'h2;
  localparam logic [15:0] RST_REM_CAP     = 16'h0100;
  localparam logic [15:0] RST_CYCLE_THR   = 16'h1000;

  // Arithmetic scaling
  localparam int          SCALE_LSB     = 32;
  localparam int          EFF_SHIFT     = 8;
  localparam logic [31:0] MWH_DIVISOR   = 32'h0000_2710;

  localparam logic [2:0] LEDS_THREE = 3'h3;
  localparam logic [2:0] LEDS_FOUR  = 3'h4;
  localparam logic [2:0] LEDS_FIVE  = 3'h5;
  localparam logic [2:0] CELLS_NONE = 3'h0;
  localparam logic [2:0] CELLS_TWO  = 3'h2;
  localparam logic [2:0] CELLS_THREE = 3'h3;
  localparam logic [2:0] CELLS_FOUR = 3'h4;

  typedef struct packed {
    logic       led_source_select;
    logic [2:0] led_count;
    logic       host_alarm_pec_on;
    logic       charger_broadcast_pec_on;
    logic       broadcast_disable;
    logic       broadcast_enable;
    logic [2:0] cell_count;
    logic       mwh_mode;
  } gpcs_opt_s;

  typedef enum logic [1:0] {SLP_IDLE, SLP_SAVE, SLP_READY} gpcs_sleep_e;

endpackage

/* gauge_pack_config_store.sv */
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
// How it works
// - Bit 7 picks absolute or relative charge LEDs
// - LED field: 00/11 five, 01 three, 10 four
// - Host PEC bit adds PEC to alarms
// - Charger PEC bit adds PEC to broadcasts
// - Broadcast disable bit stops all broadcasts
// - Mode writes cannot re-enable disabled broadcasts
// - Cell field: 11 four, 10 three, 01 two
// - Offsets refreshed when sleep conditions met
// - Conversions scaled by gain and gain factor
// - Filter value sets current filter threshold
// - Design capacity in mAh or 10 mWh
// - Full capacity updated after learning cycle
// - Alarm thresholds held in minutes and capacity
// - Stored seed starts the reported cycle count
// - Cycle count steps at discharge threshold
// - Added charge scaled by efficiency code
module gpcs_store
  import gpcs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [10:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output gpcs_opt_s        pack_opt,
  input  wire logic        sleep_conditions_met,
  input  wire logic [15:0] counter_offset_in,
  input  wire logic [7:0]  ground_offset_in,
  input  wire logic [7:0]  converter_offset_in,
  output logic             sleep_ready,
  input  wire logic        conv_valid,
  input  wire logic [15:0] conv_sample,
  output logic             scaled_valid,
  output logic      [15:0] scaled_charge,
  input  wire logic        learn_done,
  input  wire logic [15:0] learned_capacity,
  input  wire logic        dsg_valid,
  input  wire logic [15:0] dsg_mah,
  output logic      [15:0] cycle_count,
  input  wire logic        chg_valid,
  input  wire logic [15:0] chg_mah,
  output logic             eff_valid,
  output logic      [15:0] eff_charge,
  output logic      [15:0] design_capacity_rpt,
  output logic      [15:0] full_capacity_out,
  output logic      [7:0]  filter_threshold_out,
  output logic      [15:0] rem_time_alarm_out,
  output logic      [15:0] rem_cap_alarm_out
);

  logic [15:0] rem_time_alarm_reg;
  logic [15:0] design_voltage_reg;
  logic [15:0] cycle_seed_reg;
  logic [7:0]  pack_option_reg;
  logic [7:0]  filter_reg;
  logic [15:0] design_cap_reg;
  logic [15:0] full_cap_reg;
  logic [7:0]  charge_eff_reg;
  logic [15:0] sense_gain_reg;
  logic [31:0] counter_gain_reg;
  logic [15:0] counter_offset_reg;
  logic [7:0]  ground_offset_reg;
  logic [7:0]  conv_offset_reg;
  logic [7:0]  fault_clear_reg;
  logic [15:0] end_dsg_reg;
  logic [7:0]  extra_option_reg;
  logic [1:0]  batt_mode_reg;
  logic [15:0] rem_cap_reg;
  logic [15:0] cycle_thr_reg;
  logic [15:0] cycle_now_reg;
  logic [16:0] dsg_acc_reg;
  logic [INT_W-1:0] int_stat_reg;
  logic [INT_W-1:0] int_mask_reg;
  logic [INT_W-1:0] int_set;
  gpcs_sleep_e sleep_state_reg;
  logic        wr_en;
  logic [8:0]  idx;
  logic [31:0] rd_next;
  logic [31:0] wr_word;
  logic [16:0] dsg_sum;
  logic [32:0] gain_prod;
  logic [65:0] full_prod;
  logic [24:0] eff_prod;
  logic [31:0] mwh_prod;
  logic [31:0] mwh_quot;

  function automatic logic [31:0] merge_be(input logic [31:0] old_val, input logic [31:0] new_val,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [2:0] led_decode(input logic [1:0] f);
    case (f)
      2'b01:   led_decode = LEDS_THREE;
      2'b10:   led_decode = LEDS_FOUR;
      default: led_decode = LEDS_FIVE;
    endcase
  endfunction

  function automatic logic [2:0] cell_decode(input logic [1:0] f);
    case (f)
      2'b11:   cell_decode = CELLS_FOUR;
      2'b10:   cell_decode = CELLS_THREE;
      2'b01:   cell_decode = CELLS_TWO;
      default: cell_decode = CELLS_NONE;
    endcase
  endfunction

  function automatic gpcs_opt_s opt_decode(input logic [7:0] p, input logic [1:0] m);
    gpcs_opt_s o;
    o.led_source_select        = p[POS_LED_SOURCE];
    o.led_count                = led_decode({p[POS_LED_HIGH], p[POS_LED_LOW]});
    o.host_alarm_pec_on        = p[POS_HOST_PEC];
    o.charger_broadcast_pec_on = p[POS_CHG_PEC];
    o.broadcast_disable        = p[POS_BCAST_DIS];
    o.broadcast_enable         = m[POS_MODE_BCAST] & ~p[POS_BCAST_DIS];
    o.cell_count               = cell_decode({p[POS_CELL_HIGH], p[POS_CELL_LOW]});
    o.mwh_mode                 = m[POS_MODE_MWH];
    return o;
  endfunction

  assign idx     = avs_address[10:2];
  assign wr_en   = avs_write & ~avs_waitrequest;
  assign wr_word = merge_be(rd_next, avs_writedata, avs_byteenable);

  // One wait cycle per access keeps read data registered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_next;
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (idx == IDX_REM_TIME_ALARM) begin
      rd_next[15:0] = rem_time_alarm_reg;
    end else if (idx == IDX_DESIGN_VOLTAGE) begin
      rd_next[15:0] = design_voltage_reg;
    end else if (idx == IDX_CYCLE_SEED) begin
      rd_next[15:0] = cycle_seed_reg;
    end else if (idx == IDX_PACK_OPTION) begin
      rd_next[7:0] = pack_option_reg;
    end else if (idx == IDX_FILTER_THRESH) begin
      rd_next[7:0] = filter_reg;
    end else if (idx == IDX_DESIGN_CAP) begin
      rd_next[15:0] = design_cap_reg;
    end else if (idx == IDX_FULL_CAP) begin
      rd_next[15:0] = full_cap_reg;
    end else if (idx == IDX_CHARGE_EFF) begin
      rd_next[7:0] = charge_eff_reg;
    end else if (idx == IDX_SENSE_GAIN) begin
      rd_next[15:0] = sense_gain_reg;
    end else if (idx == IDX_COUNTER_GAIN) begin
      rd_next = counter_gain_reg;
    end else if (idx == IDX_COUNTER_OFFSET) begin
      rd_next[15:0] = counter_offset_reg;
    end else if (idx == IDX_GROUND_OFFSET) begin
      rd_next[7:0] = ground_offset_reg;
    end else if (idx == IDX_CONV_OFFSET) begin
      rd_next[7:0] = conv_offset_reg;
    end else if (idx == IDX_FAULT_CLEAR) begin
      rd_next[7:0] = fault_clear_reg;
    end else if (idx == IDX_END_DSG_ZERO) begin
      rd_next[15:0] = end_dsg_reg;
    end else if (idx == IDX_EXTRA_OPTION) begin
      rd_next[7:0] = extra_option_reg;
    end else if (idx == IDX_BATT_MODE) begin
      rd_next[1:0] = batt_mode_reg;
    end else if (idx == IDX_REM_CAP_ALARM) begin
      rd_next[15:0] = rem_cap_reg;
    end else if (idx == IDX_CYCLE_THRESH) begin
      rd_next[15:0] = cycle_thr_reg;
    end else if (idx == IDX_CYCLE_NOW) begin
      rd_next[15:0] = cycle_now_reg;
    end else if (idx == IDX_DESIGN_CAP_RPT) begin
      rd_next[15:0] = design_capacity_rpt;
    end else if (idx == IDX_INT_STATUS) begin
      rd_next[INT_W-1:0] = int_stat_reg;
    end else if (idx == IDX_INT_MASK) begin
      rd_next[INT_W-1:0] = int_mask_reg;
    end
  end

  // Plain configuration words
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rem_time_alarm_reg <= RST_REM_TIME;
      design_voltage_reg <= RST_VOLTAGE;
      cycle_seed_reg     <= RST_CYCLE_SEED;
      pack_option_reg    <= RST_PACK_OPTION;
      filter_reg         <= RST_FILTER;
      design_cap_reg     <= RST_DESIGN_CAP;
      charge_eff_reg     <= RST_CHARGE_EFF;
      sense_gain_reg     <= RST_SENSE_GAIN;
      counter_gain_reg   <= RST_COUNTER_GN;
      fault_clear_reg    <= RST_FAULT_CLEAR;
      end_dsg_reg        <= RST_END_DSG;
      extra_option_reg   <= RST_EXTRA_OPT;
      batt_mode_reg      <= RST_BATT_MODE;
      rem_cap_reg        <= RST_REM_CAP;
      cycle_thr_reg      <= RST_CYCLE_THR;
      int_mask_reg       <= '0;
    end else if (wr_en) begin
      if (idx == IDX_REM_TIME_ALARM) begin
        rem_time_alarm_reg <= wr_word[15:0];
      end else if (idx == IDX_DESIGN_VOLTAGE) begin
        design_voltage_reg <= wr_word[15:0];
      end else if (idx == IDX_CYCLE_SEED) begin
        cycle_seed_reg <= wr_word[15:0];
      end else if (idx == IDX_PACK_OPTION) begin
        pack_option_reg <= wr_word[7:0];
      end else if (idx == IDX_FILTER_THRESH) begin
        filter_reg <= wr_word[7:0];
      end else if (idx == IDX_DESIGN_CAP) begin
        design_cap_reg <= wr_word[15:0];
      end else if (idx == IDX_CHARGE_EFF) begin
        charge_eff_reg <= wr_word[7:0];
      end else if (idx == IDX_SENSE_GAIN) begin
        sense_gain_reg <= wr_word[15:0];
      end else if (idx == IDX_COUNTER_GAIN) begin
        counter_gain_reg <= wr_word;
      end else if (idx == IDX_FAULT_CLEAR) begin
        fault_clear_reg <= wr_word[7:0];
      end else if (idx == IDX_END_DSG_ZERO) begin
        end_dsg_reg <= wr_word[15:0];
      end else if (idx == IDX_EXTRA_OPTION) begin
        extra_option_reg <= wr_word[7:0];
      end else if (idx == IDX_BATT_MODE) begin
        batt_mode_reg <= wr_word[1:0];
      end else if (idx == IDX_REM_CAP_ALARM) begin
        rem_cap_reg <= wr_word[15:0];
      end else if (idx == IDX_CYCLE_THRESH) begin
        cycle_thr_reg <= wr_word[15:0];
      end else if (idx == IDX_INT_MASK) begin
        int_mask_reg <= wr_word[INT_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pack_opt <= opt_decode(RST_PACK_OPTION, RST_BATT_MODE);
    end else begin
      pack_opt <= opt_decode(pack_option_reg, batt_mode_reg);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_state_reg    <= SLP_IDLE;
      sleep_ready        <= 1'b0;
      counter_offset_reg <= RST_CNT_OFFSET;
      ground_offset_reg  <= RST_GND_OFFSET;
      conv_offset_reg    <= RST_CONV_OFFSET;
    end else begin
      case (sleep_state_reg)
        SLP_IDLE: begin
          sleep_ready <= 1'b0;
          if (sleep_conditions_met) begin
            sleep_state_reg <= SLP_SAVE;
          end
        end
        SLP_SAVE: begin
          counter_offset_reg <= counter_offset_in;
          ground_offset_reg  <= ground_offset_in;
          conv_offset_reg    <= converter_offset_in;
          sleep_ready        <= 1'b1;
          sleep_state_reg    <= SLP_READY;
        end
        default: begin
          if (!sleep_conditions_met) begin
            sleep_ready     <= 1'b0;
            sleep_state_reg <= SLP_IDLE;
          end
        end
      endcase
      // Hardware capture wins over a bus write
      if (wr_en && sleep_state_reg != SLP_SAVE) begin
        if (idx == IDX_COUNTER_OFFSET) begin
          counter_offset_reg <= wr_word[15:0];
        end else if (idx == IDX_GROUND_OFFSET) begin
          ground_offset_reg <= wr_word[7:0];
        end else if (idx == IDX_CONV_OFFSET) begin
          conv_offset_reg <= wr_word[7:0];
        end
      end
    end
  end

  // Learned value beats a bus write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      full_cap_reg <= RST_FULL_CAP;
    end else if (learn_done) begin
      full_cap_reg <= learned_capacity;
    end else if (wr_en && idx == IDX_FULL_CAP) begin
      full_cap_reg <= wr_word[15:0];
    end
  end

  assign dsg_sum = dsg_acc_reg + {1'b0, dsg_mah};

  // Seed write reloads the live count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cycle_now_reg <= RST_CYCLE_SEED;
      dsg_acc_reg   <= '0;
    end else if (wr_en && idx == IDX_CYCLE_SEED) begin
      cycle_now_reg <= wr_word[15:0];
      dsg_acc_reg   <= '0;
    end else if (dsg_valid) begin
      // A zero threshold never counts
      if (cycle_thr_reg != '0 && dsg_sum >= {1'b0, cycle_thr_reg}) begin
        cycle_now_reg <= cycle_now_reg + 16'h0001;
        dsg_acc_reg   <= dsg_sum - {1'b0, cycle_thr_reg};
      end else begin
        dsg_acc_reg <= dsg_sum;
      end
    end
  end

  assign gain_prod = $signed(conv_sample) * $signed({1'b0, sense_gain_reg});
  assign full_prod = $signed(gain_prod) * $signed({1'b0, counter_gain_reg});
  assign eff_prod  = chg_mah * ({1'b0, charge_eff_reg} + 9'h001);
  // mAh times mV over ten thousand
  assign mwh_prod  = design_cap_reg * design_voltage_reg;
  assign mwh_quot  = mwh_prod / MWH_DIVISOR;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scaled_valid  <= 1'b0;
      scaled_charge <= '0;
      eff_valid     <= 1'b0;
      eff_charge    <= '0;
    end else begin
      scaled_valid <= conv_valid;
      eff_valid    <= chg_valid;
      if (conv_valid) begin
        scaled_charge <= full_prod[SCALE_LSB +: 16];
      end
      if (chg_valid) begin
        eff_charge <= eff_prod[EFF_SHIFT +: 16];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      design_capacity_rpt  <= RST_DESIGN_CAP;
      full_capacity_out    <= RST_FULL_CAP;
      filter_threshold_out <= RST_FILTER;
      rem_time_alarm_out   <= RST_REM_TIME;
      rem_cap_alarm_out    <= RST_REM_CAP;
      cycle_count          <= RST_CYCLE_SEED;
    end else begin
      design_capacity_rpt  <= batt_mode_reg[POS_MODE_MWH] ? mwh_quot[15:0] : design_cap_reg;
      full_capacity_out    <= full_cap_reg;
      filter_threshold_out <= filter_reg;
      rem_time_alarm_out   <= rem_time_alarm_reg;
      rem_cap_alarm_out    <= rem_cap_reg;
      cycle_count          <= cycle_now_reg;
    end
  end

  // Sticky events; set wins over a write-one clear
  always_comb begin
    int_set            = '0;
    int_set[INT_SLEEP] = (sleep_state_reg == SLP_SAVE);
    int_set[INT_LEARN] = learn_done;
    int_set[INT_CYCLE] = dsg_valid && !(wr_en && idx == IDX_CYCLE_SEED) && cycle_thr_reg != '0 &&
                         dsg_sum >= {1'b0, cycle_thr_reg};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      if (wr_en && idx == IDX_INT_STATUS) begin
        // Unselected lane must not clear live bits
        int_stat_reg <= (int_stat_reg & ~(avs_writedata[INT_W-1:0] & {INT_W{avs_byteenable[0]}})) | int_set;
      end else begin
        int_stat_reg <= int_stat_reg | int_set;
      end
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_led_count_map: assert property (
    ##1 pack_opt.led_count == led_decode($past(pack_option_reg[POS_LED_HIGH:POS_LED_LOW])))
    else $error("led count decode wrong");
  a_cell_count_map: assert property (
    ##1 pack_opt.cell_count == cell_decode($past(pack_option_reg[POS_CELL_HIGH:POS_CELL_LOW])))
    else $error("cell count decode wrong");
  a_led_source_bit: assert property (
    ##1 pack_opt.led_source_select == $past(pack_option_reg[POS_LED_SOURCE]))
    else $error("led source wrong");
  a_pec_bits_follow: assert property (
    ##1 pack_opt.host_alarm_pec_on == $past(pack_option_reg[POS_HOST_PEC]) &&
    pack_opt.charger_broadcast_pec_on == $past(pack_option_reg[POS_CHG_PEC]))
    else $error("pec option wrong");
  a_bcast_disable_wins: assert property (
    ##1 $past(pack_option_reg[POS_BCAST_DIS]) |-> !pack_opt.broadcast_enable)
    else $error("broadcast on while disabled");
  a_sleep_refresh_seq: assert property (
    (sleep_state_reg == SLP_IDLE && sleep_conditions_met) ##1 1 |=>
    counter_offset_reg == $past(counter_offset_in) && sleep_ready)
    else $error("offsets not refreshed");
  a_learn_update: assert property (
    learn_done |=> full_cap_reg == $past(learned_capacity) ##1 full_capacity_out == $past(full_cap_reg))
    else $error("full capacity not learned");
  a_cycle_step: assert property (
    int_set[INT_CYCLE] |=> cycle_now_reg == $past(cycle_now_reg) + 16'h0001 && int_stat_reg[INT_CYCLE])
    else $error("cycle count not stepped");
  a_wait_answer: assert property (
    (avs_read && avs_waitrequest) |=> !avs_waitrequest && avs_readdata == $past(rd_next))
    else $error("read answer late");
  a_irq_level: assert property (
    ##1 irq == |$past(int_stat_reg & int_mask_reg))
    else $error("irq level wrong");

  c_sleep_cycle: cover property (sleep_state_reg == SLP_SAVE ##1 sleep_ready);
  c_mode_gated: cover property (pack_opt.broadcast_disable && batt_mode_reg[POS_MODE_BCAST]);
  c_cycle_event: cover property (int_set[INT_CYCLE] ##2 irq);
  c_clear_race: cover property (wr_en && idx == IDX_INT_STATUS && |int_set);

endmodule // gpcs_store

/* gpcs_far.sv */
`timescale 1ns/1ps
module gpcs_far
  import gpcs_pkg::*;
#(
  parameter logic [15:0] CNT_OFF  = 16'h5a3c,
  parameter logic [7:0]  GND_OFF  = 8'h2d,
  parameter logic [7:0]  CONV_OFF = 8'h4e
)(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        go,
  input  wire logic        sleep_ready,
  output logic             sleep_conditions_met,
  output logic      [15:0] counter_offset_in,
  output logic      [7:0]  ground_offset_in,
  output logic      [7:0]  converter_offset_in
);
  // Drop sleep request once refresh is reported
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) sleep_conditions_met <= 1'b0;
    else if (sleep_ready) sleep_conditions_met <= 1'b0;
    else if (go) sleep_conditions_met <= 1'b1;
  end
  // Inverted values outside a refresh, so stale capture shows
  assign counter_offset_in   = sleep_conditions_met ? CNT_OFF : ~CNT_OFF;
  assign ground_offset_in    = sleep_conditions_met ? GND_OFF : ~GND_OFF;
  assign converter_offset_in = sleep_conditions_met ? CONV_OFF : ~CONV_OFF;
endmodule // gpcs_far

/* tb.sv */
`timescale 1ns/1ps
module tb
  import gpcs_pkg::*;
;
  logic sys_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, go = 0;
  logic dsg_valid = 0, chg_valid = 0, conv_valid = 0, learn_done = 0, wr, ir, rdy, met, ev, sv;
  logic [10:0] avs_address = 0;
  logic [31:0] wd = 0, rd, rq;
  logic [15:0] dsg_mah = 0, chg_mah = 0, cs = 0, lc = 0, co, cc, ec, sc, dcr, fco, rta, rca;
  logic [7:0] go_off, vo_off, fto;
  longint p;
  gpcs_opt_s po;
  int fail_count = 0, compares = 0, cyc = 0, v, e, m;
  int mdl[int];
  gpcs_store uut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rq),
    .avs_waitrequest(wr), .irq(ir), .pack_opt(po), .sleep_conditions_met(met), .counter_offset_in(co),
    .ground_offset_in(go_off), .converter_offset_in(vo_off), .sleep_ready(rdy), .conv_valid(conv_valid),
    .conv_sample(cs), .scaled_valid(sv), .scaled_charge(sc), .learn_done(learn_done),
    .learned_capacity(lc), .dsg_valid(dsg_valid), .dsg_mah(dsg_mah), .cycle_count(cc),
    .chg_valid(chg_valid), .chg_mah(chg_mah), .eff_valid(ev), .eff_charge(ec), .design_capacity_rpt(dcr),
    .full_capacity_out(fco), .filter_threshold_out(fto), .rem_time_alarm_out(rta), .rem_cap_alarm_out(rca));
  gpcs_far far (.sys_clk(sys_clk), .arst_n(arst_n), .go(go), .sleep_ready(rdy),
    .sleep_conditions_met(met), .counter_offset_in(co), .ground_offset_in(go_off),
    .converter_offset_in(vo_off));
  always #2.5 sys_clk = ~sys_clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard; whole run is a few hundred cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  // Request held until waitrequest sampled low
  task automatic bus(bit w, logic [8:0] idx, logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    wd <= d;
    do @(posedge sys_clk); while (wr !== 1'b0);
    rd = rq;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w) mdl[idx] = d;
  endtask
  initial begin
    void'($urandom(32'ha93c03e9));
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    bus(0, IDX_PACK_OPTION, 0);
    chk("opt_reset", rd, {24'h0, RST_PACK_OPTION});
    for (int i = 0; i < 8; i++) begin
      v = ($urandom & 'h9c) | ((i % 4) * 'h21);
      bus(1, IDX_PACK_OPTION, v);
      bus(1, IDX_BATT_MODE, 2);
      repeat (2) @(posedge sys_clk);
      e = (v >> 5) & 3;
      chk("led_src", po.led_source_select, (v >> 7) & 1);
      chk("led_cnt", po.led_count, e == 1 ? 3 : e == 2 ? 4 : 5);
      chk("host_pec", po.host_alarm_pec_on, (v >> 4) & 1);
      chk("chg_pec", po.charger_broadcast_pec_on, (v >> 3) & 1);
      chk("bc_dis", po.broadcast_disable, (v >> 2) & 1);
      chk("bc_en", po.broadcast_enable, ((v >> 2) & 1) ^ 1);
      chk("cells", po.cell_count, (v & 3) == 0 ? 0 : (v & 3) + 1);
      bus(0, IDX_PACK_OPTION, 0);
      chk("opt_rd", rd, mdl[IDX_PACK_OPTION]);
    end
    bus(0, 9'h1ff, 0);
    chk("unmapped", rd, 0);
    bus(1, IDX_INT_MASK, 0);
    go <= 1'b1;
    for (int k = 0; k < 50 && rdy !== 1'b1; k++) @(posedge sys_clk);
    go <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("irq_masked", ir, 0);
    bus(0, IDX_COUNTER_OFFSET, 0);
    chk("cnt_off", rd, 32'h0000_5a3c);
    bus(0, IDX_GROUND_OFFSET, 0);
    chk("gnd_off", rd, 32'h0000_002d);
    bus(0, IDX_CONV_OFFSET, 0);
    chk("conv_off", rd, 32'h0000_004e);
    bus(1, IDX_INT_MASK, 1);
    repeat (2) @(posedge sys_clk);
    chk("irq_set", ir, 1);
    bus(1, IDX_INT_STATUS, 1);
    repeat (2) @(posedge sys_clk);
    chk("irq_clr", ir, 0);
    m = $urandom & 'hff;
    bus(1, IDX_CHARGE_EFF, m);
    v = $urandom & 'hffff;
    chg_mah <= v;
    chg_valid <= 1'b1;
    @(posedge sys_clk);
    chg_valid <= 1'b0;
    @(posedge sys_clk);
    chk("eff_vld", ev, 1);
    chk("eff", ec, ((v * (m + 1)) >> 8) & 'hffff);
    bus(1, IDX_CYCLE_THRESH, 'h10);
    bus(1, IDX_CYCLE_SEED, 5);
    repeat (3) @(posedge sys_clk);
    chk("seed", cc, 5);
    dsg_mah <= 16'h0010;
    dsg_valid <= 1'b1;
    @(posedge sys_clk);
    dsg_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("cycles", cc, 6);
    // Gain then gain factor on one conversion
    e = $urandom & 'hffff;
    m = $urandom & 'h1ffff;
    bus(1, IDX_SENSE_GAIN, e);
    bus(1, IDX_COUNTER_GAIN, m);
    v = $urandom & 'hffff;
    cs <= v;
    conv_valid <= 1'b1;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    @(posedge sys_clk);
    p = longint'(shortint'(v)) * e * m;
    chk("scl_vld", sv, 1);
    chk("scaled", sc, (p >>> SCALE_LSB) & 'hffff);
    // Registered copies, then mWh scaling
    e = $urandom & 'hffff;
    m = $urandom & 'hffff;
    bus(1, IDX_DESIGN_CAP, e);
    bus(1, IDX_DESIGN_VOLTAGE, m);
    bus(1, IDX_FILTER_THRESH, v & 'hff);
    bus(1, IDX_REM_TIME_ALARM, v);
    bus(1, IDX_REM_CAP_ALARM, e);
    repeat (2) @(posedge sys_clk);
    chk("cap_mah", dcr, e);
    chk("filter", fto, v & 'hff);
    chk("rem_time", rta, v);
    chk("rem_cap", rca, e);
    bus(1, IDX_BATT_MODE, 3);
    repeat (2) @(posedge sys_clk);
    chk("cap_mwh", dcr, (longint'(e) * m / MWH_DIVISOR) & 'hffff);
    // Learned capacity replaces the stored one
    lc <= v;
    learn_done <= 1'b1;
    @(posedge sys_clk);
    learn_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("full_cap", fco, v);
    complete_run();
  end
endmodule // tb
